// ---- hw/ccd_clock_config.sv ----
// Purpose: Divider, phase, skew, slew and output-gate configuration of a clock synthesizer
// Assumes: i_clk stands in for the synthesizer source; byte access comes from the bus engine
// Notes:   Delay codes go to analog cells as codes plus picosecond figures; slew codes go as decoded strengths
//
// Operation
// - Memory clock ratio from first divider byte upper nibble, primary table.
// - Processor clock ratio from first divider byte lower nibble, primary table.
// - Graphics clock ratio from second divider byte upper nibble, primary table.
// - Link clock ratio from second divider byte lower nibble, primary table.
// - Slot clock ratio from third divider byte lower nibble; latched default.
// - Primary table: base 2,3,5,7 scaled by 1,2,4,8.
// - Secondary table: base 4,3,5,7 scaled by 1,2,4,8.
// - Third divider byte bits 7..4 invert graphics, link, memory, processor.
// - Processor coarse delay 0..750 ps in 250 ps steps, reset code 11.
// - Memory coarse delay 0..750 ps after processor, reset code 00.
// - Free-run bit frees mid-rate group from processor clock, reset 0.
// - Link delay 1.85 to 4.10 ns, 0.15 ns steps, reset 1000.
// - Graphics delay on the same ladder, reset 1000.
// - Free-running slot delay on the ladder, reset 0100.
// - Stoppable slot delay on the ladder, reset 0100.
// - Slew codes: 01 strong, 10 weak, else normal; reset 00.
// - Same slew coding for memory and both slot groups.
// - Output byte: current reference, pin readback, six output gates.
// - Programmed ratios ignored unless programming enable is set.

`timescale 1ns/1ps

module ccd_clock_config
  import ccd_pkg::*;
#(
  parameter logic [5:0] FREE_RUN_RATIO = 6'h03
)
(
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  // Byte access
  input  wire ccd_pkg::ccd_req_t   i_req,
  output logic [7:0]               o_rdata,
  output logic                     o_rd_valid,
  // Straps and enables
  input  wire ccd_pkg::ccd_div_t   i_latched_div,
  input  wire logic                i_prog_enable,
  input  wire logic                i_drive_multiplier_pin,
  // Clock outputs and analog controls
  output ccd_pkg::ccd_clk_t        o_clk,
  output ccd_pkg::ccd_ctl_t        o_ctl
);
  import ccd_pkg::*;

  typedef struct packed {
    logic [CCD_NUM_REGS-1:0][7:0] cfg;
    logic [CCD_NUM_GRP-1:0][5:0]  ratio;
    logic [CCD_NUM_GRP-1:0][5:0]  cnt;
    logic [CCD_NUM_GRP-1:0]       flip;
    logic [CCD_NUM_GRP-1:0]       clk;
    logic                         mem_out;
    logic [2:0]                   mult_sync;
    logic                         mult_stable;
    ccd_ctl_t                     ctl;
    logic [7:0]                   rdata;
    logic                         rd_valid;
  } ccd_state_t;

  ccd_state_t                  st_reg;
  ccd_state_t                  st_next;
  logic [CCD_NUM_GRP-1:0][5:0] eff_ratio;
  logic [CCD_NUM_GRP-1:0]      flip_src;

  function automatic logic [5:0] prim_ratio(input logic [3:0] f);
    logic [5:0] base;
    base = 6'h00;
    case (f[1:0])
      2'b00:   base = 6'h02;
      2'b01:   base = 6'h03;
      2'b10:   base = 6'h05;
      default: base = 6'h07;
    endcase
    return 6'(base << f[3:2]);
  endfunction

  function automatic logic [5:0] sec_ratio(input logic [3:0] f);
    logic [5:0] r;
    r = prim_ratio(f);
    if (f[1:0] == 2'b00)
    begin
      r = 6'(6'h04 << f[3:2]);
    end
    return r;
  endfunction

  function automatic logic [12:0] ladder_ps(input logic [3:0] code);
    return 13'(CCD_LADDER_BASE_PS + CCD_LADDER_STEP_PS * int'(code));
  endfunction

  function automatic logic [9:0] coarse_ps(input logic [1:0] code);
    return 10'(CCD_COARSE_STEP_PS * int'(code));
  endfunction

  function automatic ccd_slew_t slew_decode(input logic [1:0] code);
    ccd_slew_t s;
    s = CCD_SLEW_NORMAL;
    case (code)
      2'b01:   s = CCD_SLEW_STRONG;
      2'b10:   s = CCD_SLEW_WEAK;
      default: s = CCD_SLEW_NORMAL;
    endcase
    return s;
  endfunction

  function automatic logic [7:0] write_mask(input logic [7:0] addr);
    logic [7:0] m;
    m = 8'hff;
    case (addr)
      CCD_OFS_COARSE_SKEW: m = CCD_WMASK_COARSE_SKEW;
      CCD_OFS_SLEW_HIGH:   m = CCD_WMASK_SLEW_HIGH;
      CCD_OFS_OUT_GATE:    m = CCD_WMASK_OUT_GATE;
      default:             m = 8'hff;
    endcase
    return m;
  endfunction

  function automatic logic in_map(input logic [7:0] addr);
    return (addr >= CCD_OFS_MEM_PROC_DIV) && (addr <= CCD_OFS_OUT_GATE);
  endfunction

  function automatic int reg_idx(input logic [7:0] addr);
    return int'(addr - CCD_OFS_MEM_PROC_DIV);
  endfunction

  // Effective ratio per group; straps rule while programming is off, except graphics while the free-run bit is set
  always_comb
  begin
    if (i_prog_enable)
    begin
      eff_ratio[CCD_GRP_MEM]  = prim_ratio(st_reg.cfg[0][7:4]);
      eff_ratio[CCD_GRP_PROC] = prim_ratio(st_reg.cfg[0][3:0]);
      eff_ratio[CCD_GRP_GFX]  = prim_ratio(st_reg.cfg[1][7:4]);
      eff_ratio[CCD_GRP_LINK] = prim_ratio(st_reg.cfg[1][3:0]);
      eff_ratio[CCD_GRP_SLOT] = sec_ratio(st_reg.cfg[2][3:0]);
    end
    else
    begin
      eff_ratio[CCD_GRP_MEM]  = prim_ratio(i_latched_div.memory);
      eff_ratio[CCD_GRP_PROC] = prim_ratio(i_latched_div.processor);
      eff_ratio[CCD_GRP_GFX]  = prim_ratio(i_latched_div.graphics);
      eff_ratio[CCD_GRP_LINK] = prim_ratio(i_latched_div.link);
      eff_ratio[CCD_GRP_SLOT] = sec_ratio(i_latched_div.slot);
    end
    // Free-running mid-rate group leaves the processor-derived ratio
    if (st_reg.cfg[3][CCD_BIT_FREE_RUN])
    begin
      eff_ratio[CCD_GRP_GFX] = FREE_RUN_RATIO;
    end
  end

  // Slot group has no inversion bit
  assign flip_src = {1'b0, st_reg.cfg[2][6], st_reg.cfg[2][7], st_reg.cfg[2][5], st_reg.cfg[2][4]};

  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;

    // Pin readback: second and third stage must agree before it counts
    st_next.mult_sync = {st_reg.mult_sync[1:0], i_drive_multiplier_pin};
    if (st_reg.mult_sync[2] == st_reg.mult_sync[1])
    begin
      st_next.mult_stable = st_reg.mult_sync[2];
    end

    if (i_req.wr && in_map(i_req.addr))
    begin
      st_next.cfg[reg_idx(i_req.addr)] = i_req.wdata & write_mask(i_req.addr);
    end

    // Unmapped reads answer zero
    if (i_req.rd)
    begin
      st_next.rd_valid = 1'b1;
      st_next.rdata    = 8'h00;
      if (in_map(i_req.addr))
      begin
        st_next.rdata = st_reg.cfg[reg_idx(i_req.addr)];
        if (i_req.addr == CCD_OFS_OUT_GATE)
        begin
          st_next.rdata[CCD_BIT_MULT_PIN] = st_reg.mult_stable;
        end
      end
    end

    // Dividers reload only at wrap so no runt pulse reaches a load
    for (int g = 0; g < CCD_NUM_GRP; g++)
    begin
      if (st_reg.cnt[g] >= st_reg.ratio[g] - 6'h01)
      begin
        st_next.cnt[g]   = 6'h00;
        st_next.ratio[g] = eff_ratio[g];
        st_next.flip[g]  = flip_src[g];
      end
      else
      begin
        st_next.cnt[g] = st_reg.cnt[g] + 6'h01;
      end
      st_next.clk[g] = st_next.flip[g] ^ (st_next.cnt[g] < (st_next.ratio[g] >> 1));
    end
    st_next.mem_out = st_next.clk[CCD_GRP_MEM] & st_reg.cfg[8][CCD_BIT_MEM_GATE];

    st_next.ctl.proc_coarse_code     = st_reg.cfg[3][7:6];
    st_next.ctl.proc_coarse_ps       = coarse_ps(st_reg.cfg[3][7:6]);
    st_next.ctl.mem_coarse_code      = st_reg.cfg[3][5:4];
    st_next.ctl.mem_coarse_ps        = coarse_ps(st_reg.cfg[3][5:4]);
    st_next.ctl.mid_rate_free_run    = st_reg.cfg[3][CCD_BIT_FREE_RUN];
    st_next.ctl.link_delay_code      = st_reg.cfg[4][7:4];
    st_next.ctl.link_delay_ps        = ladder_ps(st_reg.cfg[4][7:4]);
    st_next.ctl.gfx_delay_code       = st_reg.cfg[4][3:0];
    st_next.ctl.gfx_delay_ps         = ladder_ps(st_reg.cfg[4][3:0]);
    st_next.ctl.free_slot_delay_code = st_reg.cfg[5][7:4];
    st_next.ctl.free_slot_delay_ps   = ladder_ps(st_reg.cfg[5][7:4]);
    st_next.ctl.stop_slot_delay_code = st_reg.cfg[5][3:0];
    st_next.ctl.stop_slot_delay_ps   = ladder_ps(st_reg.cfg[5][3:0]);
    st_next.ctl.usb_sel_slew         = slew_decode(st_reg.cfg[6][7:6]);
    st_next.ctl.gfx_slew             = slew_decode(st_reg.cfg[6][5:4]);
    st_next.ctl.link_slew            = slew_decode(st_reg.cfg[6][3:2]);
    st_next.ctl.ref_slew             = slew_decode(st_reg.cfg[6][1:0]);
    st_next.ctl.mem_slew             = slew_decode(st_reg.cfg[7][7:6]);
    st_next.ctl.free_slot_slew       = slew_decode(st_reg.cfg[7][3:2]);
    st_next.ctl.stop_slot_slew       = slew_decode(st_reg.cfg[7][1:0]);
    st_next.ctl.iref_enable          = st_reg.cfg[8][7];
    st_next.ctl.drive_multiplier     = st_reg.mult_stable;
    st_next.ctl.mem_enable           = st_reg.cfg[8][5];
    st_next.ctl.usb48_enable         = st_reg.cfg[8][4];
    st_next.ctl.usb_sel_enable       = st_reg.cfg[8][3];
    st_next.ctl.ref_enable           = st_reg.cfg[8][2:0];
  end

  // Synchronous reset may load the strap nibbles
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      st_reg          <= '0;
      st_reg.cfg[0]   <= {i_latched_div.memory, i_latched_div.processor};
      st_reg.cfg[1]   <= {i_latched_div.graphics, i_latched_div.link};
      st_reg.cfg[2]   <= {CCD_RST_INV_HIGH[7:4], i_latched_div.slot};
      st_reg.cfg[3]   <= CCD_RST_COARSE_SKEW;
      st_reg.cfg[4]   <= CCD_RST_LINK_GFX_DLY;
      st_reg.cfg[5]   <= CCD_RST_SLOT_DLY;
      st_reg.cfg[6]   <= CCD_RST_SLEW_LOW;
      st_reg.cfg[7]   <= CCD_RST_SLEW_HIGH;
      st_reg.cfg[8]   <= CCD_RST_OUT_GATE & CCD_WMASK_OUT_GATE;
      st_reg.ratio    <= {CCD_NUM_GRP{6'h02}};
      st_reg.clk      <= {CCD_NUM_GRP{1'b1}};
      st_reg.mult_sync <= 3'h7;
      st_reg.mult_stable <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_rdata    = st_reg.rdata;
  assign o_rd_valid = st_reg.rd_valid;
  assign o_ctl      = st_reg.ctl;
  assign o_clk      = '{slot: st_reg.clk[CCD_GRP_SLOT], link: st_reg.clk[CCD_GRP_LINK],
                        graphics: st_reg.clk[CCD_GRP_GFX], memory: st_reg.mem_out,
                        processor: st_reg.clk[CCD_GRP_PROC]};

  AST_MEM_RATIO:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prog_enable && st_reg.cfg[0][7:4] == 4'hf) |-> eff_ratio[CCD_GRP_MEM] == 6'd56)
    else $error("memory ratio not 56 for code f");

  AST_PROC_RATIO:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prog_enable && st_reg.cfg[0][3:0] == 4'h6) |-> eff_ratio[CCD_GRP_PROC] == 6'd10)
    else $error("processor ratio not 10 for code 6");

  AST_GFX_RATIO:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prog_enable && !st_reg.cfg[3][0] && st_reg.cfg[1][7:4] == 4'h5) |-> eff_ratio[CCD_GRP_GFX] == 6'd6)
    else $error("graphics ratio not 6 for code 5");

  AST_LINK_RATIO:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prog_enable && st_reg.cfg[1][3:0] == 4'hb) |-> eff_ratio[CCD_GRP_LINK] == 6'd28)
    else $error("link ratio not 28 for code b");

  AST_SLOT_SEC:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prog_enable && st_reg.cfg[2][3:0] == 4'hc) |-> eff_ratio[CCD_GRP_SLOT] == 6'd32)
    else $error("slot ratio not 32 for code c");

  AST_PRIM_BASE:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_prog_enable && st_reg.cfg[0][3:0] == 4'h0) |-> eff_ratio[CCD_GRP_PROC] == 6'd2)
    else $error("primary table base not 2");

  AST_FLIP_PHASE:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.cnt[CCD_GRP_PROC] == 6'h00 |-> st_reg.clk[CCD_GRP_PROC] != st_reg.flip[CCD_GRP_PROC])
    else $error("processor phase does not follow inversion");

  AST_PROC_COARSE:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.cfg[3][7:6] == 2'b11 |=> o_ctl.proc_coarse_ps == 10'd750)
    else $error("processor coarse delay not 750 ps");

  AST_FREE_RUN:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.cfg[3][0] |-> eff_ratio[CCD_GRP_GFX] == FREE_RUN_RATIO)
    else $error("mid-rate group not free running");

  AST_LINK_LADDER:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.cfg[4][7:4] == 4'hf |=> o_ctl.link_delay_ps == 13'd4100)
    else $error("link delay top step not 4100 ps");

  AST_SLEW_STRONG:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st_reg.cfg[6][5:4] == 2'b01 |=> o_ctl.gfx_slew == CCD_SLEW_STRONG)
    else $error("graphics slew code 01 not strong");

  AST_MEM_GATE:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !st_reg.cfg[8][5] |=> !o_clk.memory)
    else $error("memory clock runs while gated");

  AST_STRAP_RULES:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !i_prog_enable |-> eff_ratio[CCD_GRP_MEM] == prim_ratio(i_latched_div.memory))
    else $error("programmed ratio used while programming disabled");

  AST_WRAP_ONLY:
  assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $changed(st_reg.ratio[CCD_GRP_LINK]) |-> $past(st_reg.cnt[CCD_GRP_LINK]) == $past(st_reg.ratio[CCD_GRP_LINK]) - 6'h01)
    else $error("link ratio changed mid period");

endmodule

// ---- common/ccd_pkg.sv ----
// Purpose: Shared constants and carriers for the clock divider and skew configuration block
// Assumes: Byte-indexed configuration access from the two-wire management bus engine
// Notes:   Offsets are the byte indices the host uses

package ccd_pkg;

  // Register byte indices
  localparam logic [7:0] CCD_OFS_MEM_PROC_DIV  = 8'h0f;
  localparam logic [7:0] CCD_OFS_GFX_LINK_DIV  = 8'h10;
  localparam logic [7:0] CCD_OFS_INV_SLOT_DIV  = 8'h11;
  localparam logic [7:0] CCD_OFS_COARSE_SKEW   = 8'h12;
  localparam logic [7:0] CCD_OFS_LINK_GFX_DLY  = 8'h13;
  localparam logic [7:0] CCD_OFS_SLOT_DLY      = 8'h14;
  localparam logic [7:0] CCD_OFS_SLEW_LOW      = 8'h15;
  localparam logic [7:0] CCD_OFS_SLEW_HIGH     = 8'h16;
  localparam logic [7:0] CCD_OFS_OUT_GATE      = 8'h17;
  localparam int         CCD_NUM_REGS          = 9;

  // Reset values of registers that do not follow the latched select
  localparam logic [7:0] CCD_RST_INV_HIGH      = 8'h00;
  localparam logic [7:0] CCD_RST_COARSE_SKEW   = 8'hc0;
  localparam logic [7:0] CCD_RST_LINK_GFX_DLY  = 8'h88;
  localparam logic [7:0] CCD_RST_SLOT_DLY      = 8'h44;
  localparam logic [7:0] CCD_RST_SLEW_LOW      = 8'h00;
  localparam logic [7:0] CCD_RST_SLEW_HIGH     = 8'h00;
  localparam logic [7:0] CCD_RST_OUT_GATE      = 8'h7f;

  // Writable bits; reserved and read-only bits are masked
  localparam logic [7:0] CCD_WMASK_COARSE_SKEW = 8'hf1;
  localparam logic [7:0] CCD_WMASK_SLEW_HIGH   = 8'hcf;
  localparam logic [7:0] CCD_WMASK_OUT_GATE    = 8'hbf;
  localparam int         CCD_BIT_MULT_PIN      = 6;
  localparam int         CCD_BIT_FREE_RUN      = 0;
  localparam int         CCD_BIT_MEM_GATE      = 5;

  // Group indices
  localparam int         CCD_GRP_PROC          = 0;
  localparam int         CCD_GRP_MEM           = 1;
  localparam int         CCD_GRP_GFX           = 2;
  localparam int         CCD_GRP_LINK          = 3;
  localparam int         CCD_GRP_SLOT          = 4;
  localparam int         CCD_NUM_GRP           = 5;

  // Delay figures in picoseconds
  localparam int         CCD_COARSE_STEP_PS    = 250;
  localparam int         CCD_LADDER_BASE_PS    = 1850;
  localparam int         CCD_LADDER_STEP_PS    = 150;

  typedef enum logic [1:0] {CCD_SLEW_NORMAL, CCD_SLEW_STRONG, CCD_SLEW_WEAK} ccd_slew_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccd_req_t;

  typedef struct packed {
    logic [3:0] slot;
    logic [3:0] link;
    logic [3:0] graphics;
    logic [3:0] memory;
    logic [3:0] processor;
  } ccd_div_t;

  typedef struct packed {
    logic slot;
    logic link;
    logic graphics;
    logic memory;
    logic processor;
  } ccd_clk_t;

  typedef struct packed {
    logic [1:0]  proc_coarse_code;
    logic [9:0]  proc_coarse_ps;
    logic [1:0]  mem_coarse_code;
    logic [9:0]  mem_coarse_ps;
    logic        mid_rate_free_run;
    logic [3:0]  link_delay_code;
    logic [12:0] link_delay_ps;
    logic [3:0]  gfx_delay_code;
    logic [12:0] gfx_delay_ps;
    logic [3:0]  free_slot_delay_code;
    logic [12:0] free_slot_delay_ps;
    logic [3:0]  stop_slot_delay_code;
    logic [12:0] stop_slot_delay_ps;
    ccd_slew_t   usb_sel_slew;
    ccd_slew_t   gfx_slew;
    ccd_slew_t   link_slew;
    ccd_slew_t   ref_slew;
    ccd_slew_t   mem_slew;
    ccd_slew_t   free_slot_slew;
    ccd_slew_t   stop_slot_slew;
    logic        iref_enable;
    logic        drive_multiplier;
    logic        mem_enable;
    logic        usb48_enable;
    logic        usb_sel_enable;
    logic [2:0]  ref_enable;
  } ccd_ctl_t;

endpackage

// ---- tb/ccd_load_model.sv ----
// Purpose: Clock load that measures period and high time of each divided output
// Assumes: Outputs are registered on i_clk, so one sample per cycle is exact
// Notes:   Figures refresh at every rising edge; first ones after reset are junk

`timescale 1ns/1ps

module ccd_load_model
  import ccd_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // Observed clocks
  input  wire ccd_pkg::ccd_clk_t i_grp,
  // Measurements
  output logic [4:0][7:0]        o_period,
  output logic [4:0][7:0]        o_high
);
  logic [4:0][7:0] cnt_reg;
  logic [4:0][7:0] hacc_reg;
  logic [4:0]      prev_reg;
  logic [4:0]      lvl;

  assign lvl = i_grp;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      cnt_reg  <= '0;
      hacc_reg <= '0;
      prev_reg <= '0;
      o_period <= '0;
      o_high   <= '0;
    end
    else
    begin
      for (int g = 0; g < 5; g++)
      begin
        if (lvl[g] && !prev_reg[g])
        begin
          o_period[g] <= cnt_reg[g];
          o_high[g]   <= hacc_reg[g];
          cnt_reg[g]  <= 8'h01;
          hacc_reg[g] <= 8'h01;
        end
        else
        begin
          cnt_reg[g]  <= cnt_reg[g] + 8'h01;
          hacc_reg[g] <= hacc_reg[g] + {7'h00, lvl[g]};
        end
      end
      prev_reg <= lvl;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the divider and skew configuration block
// Assumes: Byte requests are one-cycle strobes driven 2 ns after the rising edge
// Notes:   Ratio changes land at a wrap, so each period and high-time check waits 180 cycles

`timescale 1ns/1ps

module tb_top;
  import ccd_pkg::*;
  localparam int FR = 3;
  logic            i_clk = 1'b0;
  logic            i_rst_b = 1'b0;
  ccd_req_t        req;
  logic [7:0]      rdata;
  logic            rd_valid;
  ccd_div_t        strap;
  logic            prog;
  logic            pin;
  ccd_clk_t        clks;
  ccd_ctl_t        ctl;
  logic [4:0][7:0] per;
  logic [4:0][7:0] hi;
  logic            seen;
  int              error_cnt = 0;
  int              n_checks = 0;

  always #12.5 i_clk = ~i_clk;

  ccd_clock_config #(.FREE_RUN_RATIO(6'h03)) dut_u (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(req), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .i_latched_div(strap), .i_prog_enable(prog), .i_drive_multiplier_pin(pin), .o_clk(clks), .o_ctl(ctl));

  ccd_load_model load_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_grp(clks), .o_period(per), .o_high(hi));

  function automatic logic [15:0] ratio(input logic [3:0] c, input bit sec);
    int b[4] = '{2, 3, 5, 7};
    if (sec && c[1:0] == 2'b00)
      return 16'(4 << c[3:2]);
    return 16'(b[c[1:0]] << c[3:2]);
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #2;
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    #2;
    req.wr = 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    int k;
    @(posedge i_clk);
    #2;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge i_clk);
    #2;
    req.rd = 1'b0;
    k = 0;
    while (rd_valid !== 1'b1 && k < 3)
    begin
      @(posedge i_clk);
      #2;
      k++;
    end
    chk("read valid", 16'h1, {15'h0, rd_valid});
    chk("read data", {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #2;
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    error_cnt++;
    wrap_up;
  end

  initial
  begin
    req = '0;
    strap = '{slot: 4'h0, link: 4'h1, graphics: 4'h1, memory: 4'h0, processor: 4'h1};
    prog = 1'b0;
    pin = 1'b1;
    wait_cyc(16);
    i_rst_b = 1'b1;
    bus_rd(CCD_OFS_MEM_PROC_DIV, 8'h01);
    bus_rd(CCD_OFS_GFX_LINK_DIV, 8'h11);
    bus_rd(CCD_OFS_INV_SLOT_DIV, 8'h00);
    bus_rd(CCD_OFS_COARSE_SKEW, 8'hc0);
    bus_rd(CCD_OFS_LINK_GFX_DLY, 8'h88);
    bus_rd(CCD_OFS_SLOT_DLY, 8'h44);
    bus_rd(CCD_OFS_SLEW_LOW, 8'h00);
    bus_rd(CCD_OFS_SLEW_HIGH, 8'h00);
    bus_rd(CCD_OFS_OUT_GATE, 8'h7f);
    chk("proc coarse ps", 16'd750, 16'(ctl.proc_coarse_ps));
    chk("link delay ps", 16'd3050, 16'(ctl.link_delay_ps));
    chk("stop slot delay ps", 16'd2450, 16'(ctl.stop_slot_delay_ps));
    // Reserved bits and unmapped bytes must refuse writes
    bus_wr(CCD_OFS_COARSE_SKEW, 8'hff);
    bus_rd(CCD_OFS_COARSE_SKEW, 8'hf1);
    bus_wr(CCD_OFS_SLEW_HIGH, 8'hff);
    bus_rd(CCD_OFS_SLEW_HIGH, 8'hcf);
    bus_wr(8'h20, 8'h5a);
    bus_rd(8'h20, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      bus_wr(CCD_OFS_COARSE_SKEW, {2'(c), 2'(3 - c), 4'h0});
      wait_cyc(2);
      chk("proc coarse ps", 16'(250 * c), 16'(ctl.proc_coarse_ps));
      chk("mem coarse ps", 16'(250 * (3 - c)), 16'(ctl.mem_coarse_ps));
      chk("coarse codes", 16'({2'(c), 2'(3 - c)}), 16'({ctl.proc_coarse_code, ctl.mem_coarse_code}));
    end
    for (int c = 0; c < 16; c++)
    begin
      bus_wr(CCD_OFS_LINK_GFX_DLY, {4'(c), ~4'(c)});
      bus_wr(CCD_OFS_SLOT_DLY, {~4'(c), 4'(c)});
      wait_cyc(2);
      chk("delay codes", {4'(c), ~4'(c), ~4'(c), 4'(c)}, {ctl.link_delay_code, ctl.gfx_delay_code,
        ctl.free_slot_delay_code, ctl.stop_slot_delay_code});
      chk("link delay ps", 16'(1850 + 150 * c), 16'(ctl.link_delay_ps));
      chk("gfx delay ps", 16'(1850 + 150 * (15 - c)), 16'(ctl.gfx_delay_ps));
      chk("free slot delay ps", 16'(1850 + 150 * (15 - c)), 16'(ctl.free_slot_delay_ps));
      chk("stop slot delay ps", 16'(1850 + 150 * c), 16'(ctl.stop_slot_delay_ps));
    end
    bus_wr(CCD_OFS_SLEW_LOW, 8'h1b);
    bus_wr(CCD_OFS_SLEW_HIGH, 8'h4b);
    wait_cyc(2);
    chk("usb slew", 16'(CCD_SLEW_NORMAL), 16'(ctl.usb_sel_slew));
    chk("gfx slew", 16'(CCD_SLEW_STRONG), 16'(ctl.gfx_slew));
    chk("link slew", 16'(CCD_SLEW_WEAK), 16'(ctl.link_slew));
    chk("mem slew", 16'(CCD_SLEW_STRONG), 16'(ctl.mem_slew));
    chk("free slot slew", 16'(CCD_SLEW_WEAK), 16'(ctl.free_slot_slew));
    chk("stop slot slew", 16'(CCD_SLEW_NORMAL), 16'(ctl.stop_slot_slew));
    bus_wr(CCD_OFS_SLEW_LOW, 8'hb1);
    wait_cyc(2);
    chk("usb slew", 16'(CCD_SLEW_WEAK), 16'(ctl.usb_sel_slew));
    chk("ref slew", 16'(CCD_SLEW_STRONG), 16'(ctl.ref_slew));
    bus_wr(CCD_OFS_OUT_GATE, 8'h95);
    wait_cyc(2);
    bus_rd(CCD_OFS_OUT_GATE, 8'hd5);
    chk("gate set", 16'h0d5, 16'({ctl.iref_enable, ctl.drive_multiplier, ctl.mem_enable, ctl.usb48_enable,
      ctl.usb_sel_enable, ctl.ref_enable}));
    seen = 1'b0;
    repeat (60)
    begin
      wait_cyc(1);
      seen = seen | clks.memory;
    end
    chk("gated memory clock", 16'h0, {15'h0, seen});
    bus_wr(CCD_OFS_OUT_GATE, 8'h3f);
    pin = 1'b0;
    wait_cyc(8);
    bus_rd(CCD_OFS_OUT_GATE, 8'h3f);
    chk("pin readback", 16'h0, {15'h0, ctl.drive_multiplier});
    pin = 1'b1;
    wait_cyc(8);
    bus_rd(CCD_OFS_OUT_GATE, 8'h7f);
    // Programmed ratios must wait for the enable
    bus_wr(CCD_OFS_MEM_PROC_DIV, 8'h33);
    wait_cyc(180);
    chk("proc period strap", 16'd3, 16'(per[CCD_GRP_PROC]));
    chk("mem period strap", 16'd2, 16'(per[CCD_GRP_MEM]));
    prog = 1'b1;
    wait_cyc(180);
    chk("proc period prog", 16'd7, 16'(per[CCD_GRP_PROC]));
    for (int c = 0; c < 16; c++)
    begin
      bus_wr(CCD_OFS_MEM_PROC_DIV, {4'(c), 4'(c)});
      bus_wr(CCD_OFS_GFX_LINK_DIV, {4'(c), 4'(c)});
      bus_wr(CCD_OFS_INV_SLOT_DIV, {4'h0, 4'(c)});
      wait_cyc(180);
      for (int g = 0; g < 4; g++)
        chk("primary period", ratio(4'(c), 1'b0), 16'(per[g]));
      chk("slot period", ratio(4'(c), 1'b1), 16'(per[CCD_GRP_SLOT]));
    end
    bus_wr(CCD_OFS_MEM_PROC_DIV, 8'h11);
    bus_wr(CCD_OFS_GFX_LINK_DIV, 8'h11);
    bus_wr(CCD_OFS_INV_SLOT_DIV, 8'hf1);
    wait_cyc(180);
    for (int g = 0; g < 4; g++)
      chk("inverted high time", 16'd2, 16'(hi[g]));
    chk("slot high time", 16'd1, 16'(hi[CCD_GRP_SLOT]));
    bus_wr(CCD_OFS_INV_SLOT_DIV, 8'h00);
    bus_wr(CCD_OFS_GFX_LINK_DIV, 8'h00);
    bus_wr(CCD_OFS_COARSE_SKEW, 8'h01);
    wait_cyc(180);
    chk("free run period", 16'(FR), 16'(per[CCD_GRP_GFX]));
    chk("link period", 16'd2, 16'(per[CCD_GRP_LINK]));
    chk("free run flag", 16'h1, {15'h0, ctl.mid_rate_free_run});
    wrap_up;
  end
endmodule
